// ---- include/rst_pkg.sv ----
package rst_pkg;
	localparam int NUM_SOURCES = 9;
	localparam logic [31:0] CAUSE_OFFSET = 32'h0000_0000;
	localparam logic [31:0] IRQ_STATUS_OFFSET = 32'h0000_0004;
	localparam logic [31:0] IRQ_MASK_OFFSET = 32'h0000_0008;
	localparam logic [31:0] WDT_STATE_OFFSET = 32'h0000_000C;
	localparam int TRAP_BIT = 15;
	localparam int ILLEGAL_BIT = 14;
	localparam int SBOR_EN_BIT = 13;
	localparam int RETAIN_BIT = 12;
	localparam int MISMATCH_BIT = 9;
	localparam int VREG_BIT = 8;
	localparam int EXT_BIT = 7;
	localparam int SOFT_BIT = 6;
	localparam int WDT_EN_BIT = 5;
	localparam int WDT_TO_BIT = 4;
	localparam int SLEEP_BIT = 3;
	localparam int IDLE_BIT = 2;
	localparam int BROWN_BIT = 1;
	localparam int POWER_BIT = 0;
	localparam logic [15:0] CAUSE_IMPL_MASK = 16'hF3FF;
	localparam logic [15:0] CAUSE_POR_VALUE = 16'h2003;
	localparam logic [1:0] FUSE_UNPROGRAMMED = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Source index order of the source vector.
	localparam int SRC_POR = 0;
	localparam int SRC_PIN = 1;
	localparam int SRC_INSTR = 2;
	localparam int SRC_WDT = 3;
	localparam int SRC_BOR = 4;
	localparam int SRC_MISMATCH = 5;
	localparam int SRC_TRAP = 6;
	localparam int SRC_ILLOP = 7;
	localparam int SRC_UNINIT = 8;
endpackage : rst_pkg

// ---- src/source_capture.sv ----
`timescale 1ns/1ps
module source_capture
	import rst_pkg::*;
#(
	parameter int WIDTH = NUM_SOURCES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] src_in,
	output logic [WIDTH-1:0] src_level,
	output logic [WIDTH-1:0] src_rise
);
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] level_next;
	logic [WIDTH-1:0] prev_next;

	always_comb begin
		level_next = src_in;
		prev_next = level_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_reg <= '0;
			prev_reg <= '0;
		end else begin
			level_reg <= level_next;
			prev_reg <= prev_next;
		end
	end

	assign src_level = level_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_edge
			// An event is the first cycle a source is seen active.
			assign src_rise[i] = level_reg[i] & ~prev_reg[i];
		end
	endgenerate
endmodule : source_capture

// ---- src/reset_combiner.sv ----
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// - The master reset output is high whenever any reset source is active.
// - Nine reset sources enter the block: power-on, pin, instruction, watchdog, brown-out, mismatch, trap, illegal opcode, uninitialised register.
// - While master reset is high, registers with a defined reset state are forced to it and others are left alone; this block does so on power-on only.
// - Each reset event sets the cause flag of its own source, except that illegal opcode and uninitialised register share bit 14.
// - Power-on clears the cause register except bits 13 and 1:0, which it sets.
// - Software may set or clear any implemented cause register bit, except while power-on is active or when an event sets that bit in the same cycle.
// - Setting a cause flag by software never raises master reset.
// - The cause register also holds watchdog and power-saving control bits.
module reset_combiner
	import rst_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_in,
	input wire logic master_clear_pin,
	input wire logic reset_instr_in,
	input wire logic watchdog_timeout_in,
	input wire logic brown_out_in,
	input wire logic config_mismatch_in,
	input wire logic trap_conflict_in,
	input wire logic illegal_opcode_in,
	input wire logic uninit_wreg_reset,
	input wire logic sleep_entry_in,
	input wire logic idle_entry_in,
	input wire logic [1:0] watchdog_fuse_enable,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic master_reset_out,
	output logic watchdog_run,
	output logic irq
);
	logic [NUM_SOURCES-1:0] src_vec;
	logic [NUM_SOURCES-1:0] src_level;
	logic [NUM_SOURCES-1:0] src_rise;

	logic [15:0] reset_cause_reg, reset_cause_next;
	logic [15:0] irq_status_reg, irq_status_next;
	logic [15:0] irq_mask_reg, irq_mask_next;
	logic master_reset_reg, master_reset_next;
	logic watchdog_run_reg, watchdog_run_next;
	logic irq_reg, irq_next;
	logic por_seen_reg, por_seen_next;

	logic aw_hold_reg, aw_hold_next;
	logic w_hold_reg, w_hold_next;
	logic [31:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic arready_reg, arready_next;

	logic wr_fire;
	logic rd_fire;
	logic [15:0] event_bits;
	logic [15:0] wr_value;

	// Byte-lane merge of a 16-bit register with a write.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction : merge16

	function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] offs);
		return addr[31:2] == offs[31:2];
	endfunction : addr_hit

	assign src_vec = {uninit_wreg_reset, illegal_opcode_in, trap_conflict_in,
		config_mismatch_in, brown_out_in, watchdog_timeout_in, reset_instr_in,
		master_clear_pin, por_in};

	source_capture #(
		.WIDTH(NUM_SOURCES)
	) u_capture (
		.aclk(aclk),
		.aresetn(aresetn),
		.src_in(src_vec),
		.src_level(src_level),
		.src_rise(src_rise)
	);

	always_comb begin
		event_bits = '0;
		event_bits[TRAP_BIT] = src_rise[SRC_TRAP];
		event_bits[ILLEGAL_BIT] = src_rise[SRC_ILLOP] | src_rise[SRC_UNINIT];
		event_bits[MISMATCH_BIT] = src_rise[SRC_MISMATCH];
		event_bits[EXT_BIT] = src_rise[SRC_PIN];
		event_bits[SOFT_BIT] = src_rise[SRC_INSTR];
		event_bits[WDT_TO_BIT] = src_rise[SRC_WDT];
		event_bits[BROWN_BIT] = src_rise[SRC_BOR];
		event_bits[SLEEP_BIT] = sleep_entry_in;
		event_bits[IDLE_BIT] = idle_entry_in;
	end

	// AXI4-Lite write channel: address and data taken in either order.
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;
	assign wr_value = merge16(reset_cause_reg, wdata_reg, wstrb_reg);

	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && !aw_hold_reg) begin
			aw_hold_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold_reg) begin
			w_hold_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			if (addr_hit(awaddr_reg, CAUSE_OFFSET) || addr_hit(awaddr_reg, IRQ_STATUS_OFFSET)
				|| addr_hit(awaddr_reg, IRQ_MASK_OFFSET)) begin
				bresp_next = RESP_OKAY;
			end else begin
				bresp_next = RESP_SLVERR;
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// Ready is registered from the next hold state, so it is always the exact inverse of the hold flag.
		awready_next = !aw_hold_next;
		wready_next = !w_hold_next;
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = '0;
			case (1'b1)
				addr_hit(s_axi_araddr, CAUSE_OFFSET): rdata_next = {16'h0000, reset_cause_reg};
				addr_hit(s_axi_araddr, IRQ_STATUS_OFFSET): rdata_next = {16'h0000, irq_status_reg};
				addr_hit(s_axi_araddr, IRQ_MASK_OFFSET): rdata_next = {16'h0000, irq_mask_reg};
				addr_hit(s_axi_araddr, WDT_STATE_OFFSET): rdata_next = {31'h0, watchdog_run_reg};
				default: rresp_next = RESP_SLVERR;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	// Cause register and the reset output. Hardware events win over a write in the same cycle.
	always_comb begin
		reset_cause_next = reset_cause_reg;
		irq_status_next = irq_status_reg;
		irq_mask_next = irq_mask_reg;
		por_seen_next = por_seen_reg;
		if (wr_fire && addr_hit(awaddr_reg, CAUSE_OFFSET)) begin
			reset_cause_next = wr_value & CAUSE_IMPL_MASK;
		end
		if (wr_fire && addr_hit(awaddr_reg, IRQ_MASK_OFFSET)) begin
			irq_mask_next = merge16(irq_mask_reg, wdata_reg, wstrb_reg);
		end
		if (wr_fire && addr_hit(awaddr_reg, IRQ_STATUS_OFFSET)) begin
			irq_status_next = irq_status_reg & ~merge16(16'h0000, wdata_reg, wstrb_reg);
		end
		reset_cause_next = reset_cause_next | event_bits;
		irq_status_next = irq_status_next | event_bits;
		if (src_level[SRC_POR]) begin
			// Power-on also forces the control bits to their defined values.
			reset_cause_next = CAUSE_POR_VALUE;
			irq_status_next = '0;
			irq_mask_next = '0;
		end
		// Only the source inputs feed this; register contents never do.
		master_reset_next = |src_level;
		// Unprogrammed fuses keep the watchdog running.
		watchdog_run_next = (watchdog_fuse_enable == FUSE_UNPROGRAMMED) ||
			reset_cause_reg[WDT_EN_BIT];
		irq_next = |(irq_status_reg & irq_mask_reg);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_cause_reg <= CAUSE_POR_VALUE;
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			master_reset_reg <= 1'b1;
			watchdog_run_reg <= 1'b0;
			irq_reg <= 1'b0;
			por_seen_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			arready_reg <= 1'b1;
		end else begin
			reset_cause_reg <= reset_cause_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			master_reset_reg <= master_reset_next;
			watchdog_run_reg <= watchdog_run_next;
			irq_reg <= irq_next;
			por_seen_reg <= por_seen_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign master_reset_out = master_reset_reg;
	assign watchdog_run = watchdog_run_reg;
	assign irq = irq_reg;

	master_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(|src_vec) |-> ##2 master_reset_out)
		else $error("master reset missed an active source");

	no_soft_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!(|src_vec) && !(|$past(src_vec))) |-> ##1 !master_reset_out)
		else $error("master reset raised without a source");

	event_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_rise[SRC_PIN] && !src_level[SRC_POR]) |=> reset_cause_reg[EXT_BIT])
		else $error("pin reset flag not set");

	illegal_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		((src_rise[SRC_UNINIT] || src_rise[SRC_ILLOP]) && !src_level[SRC_POR])
		|=> reset_cause_reg[ILLEGAL_BIT])
		else $error("illegal op flag not set");

	por_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
		src_level[SRC_POR] |=> reset_cause_reg == CAUSE_POR_VALUE)
		else $error("power-on value wrong");

	soft_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && addr_hit(awaddr_reg, CAUSE_OFFSET) && !(|src_level) && !(|event_bits))
		|=> reset_cause_reg == $past(wr_value & CAUSE_IMPL_MASK))
		else $error("software write not stored");

	fuse_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(watchdog_fuse_enable == FUSE_UNPROGRAMMED) |=> watchdog_run)
		else $error("watchdog not forced on by fuses");

	trap_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(src_rise[SRC_TRAP] && !src_level[SRC_POR]) |=> reset_cause_reg[TRAP_BIT])
		else $error("trap flag not at bit 15");

	sleep_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sleep_entry_in && !src_level[SRC_POR]) |=> reset_cause_reg[SLEEP_BIT])
		else $error("sleep entry flag not set");
endmodule : reset_combiner

// ---- test/source_model.sv ----
`timescale 1ns/1ps
module source_model (
	input wire logic aclk,
	input wire logic fire,
	input wire logic [3:0] sel,
	output logic [8:0] src
);
	logic [2:0] left_reg = 3'h0;
	logic [3:0] sel_reg = 4'h0;
	// A fault stays active for several cycles, so the combiner must not rely on one-cycle pulses.
	always_ff @(posedge aclk) begin
		if (fire) begin
			left_reg <= 3'h4;
			sel_reg <= sel;
		end else if (left_reg != 3'h0) begin
			left_reg <= left_reg - 3'h1;
		end
	end
	always_comb begin
		src = 9'h000;
		if (left_reg != 3'h0) begin
			src[sel_reg] = 1'b1;
		end
	end
endmodule : source_model

// ---- test/reset_combiner_tb.sv ----
`timescale 1ns/1ps
module reset_combiner_tb;
	import rst_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic fire = 1'b0;
	logic [3:0] sel = 4'h0;
	logic [8:0] src;
	logic [1:0] fuse = 2'h3;
	logic [3:0] strb = 4'hF;
	logic sleep_in = 1'b0;
	logic idle_in = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, mro, wrun, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] d;
	logic [1:0] r;
	int err_total = 0;
	int n_tests = 0;
	int flag_pos[9] = '{0, 7, 6, 4, 1, 9, 15, 14, 14};

	source_model partner (.aclk(aclk), .fire(fire), .sel(sel), .src(src));

	reset_combiner dut (.aclk(aclk), .aresetn(aresetn), .por_in(src[SRC_POR]),
		.master_clear_pin(src[SRC_PIN]), .reset_instr_in(src[SRC_INSTR]),
		.watchdog_timeout_in(src[SRC_WDT]), .brown_out_in(src[SRC_BOR]),
		.config_mismatch_in(src[SRC_MISMATCH]), .trap_conflict_in(src[SRC_TRAP]),
		.illegal_opcode_in(src[SRC_ILLOP]), .uninit_wreg_reset(src[SRC_UNINIT]),
		.sleep_entry_in(sleep_in), .idle_entry_in(idle_in), .watchdog_fuse_enable(fuse),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.master_reset_out(mro), .watchdog_run(wrun), .irq(irq));

	initial begin
		forever #4 aclk = ~aclk;
	end

	task end_sim;
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
		end
	endtask : check

	task timed_out;
		check(32'hDEAD, 32'h0);
		end_sim();
	endtask : timed_out

	task axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50) timed_out();
	endtask : axi_wr

	task axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				v = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50) timed_out();
	endtask : axi_rd

	task wr(input logic [31:0] a, input logic [31:0] v);
		axi_wr(a, v, r);
	endtask : wr

	task rd_chk(input logic [31:0] a, input logic [31:0] exp);
		axi_rd(a, d, r);
		check(d, exp);
	endtask : rd_chk

	task pulse(input int i);
		int n;
		@(posedge aclk);
		fire <= 1'b1;
		sel <= 4'(i);
		@(posedge aclk);
		fire <= 1'b0;
		for (n = 0; n < 8 && mro !== 1'b1; n++) @(posedge aclk);
		check(32'(mro), 32'h1);
		for (n = 0; n < 20 && mro !== 1'b0; n++) @(posedge aclk);
		check(32'(mro), 32'h0);
	endtask : pulse

	task t_sources;
		for (int i = 1; i < 9; i++) begin
			wr(CAUSE_OFFSET, 32'h0);
			pulse(i);
			rd_chk(CAUSE_OFFSET, 32'h1 << flag_pos[i]);
		end
	endtask : t_sources

	task t_soft;
		wr(CAUSE_OFFSET, 32'hFFFF);
		// Every flag set by software at once must still leave the system running.
		repeat (8) begin
			@(posedge aclk);
			check(32'(mro), 32'h0);
		end
		rd_chk(CAUSE_OFFSET, 32'hF3FF);
		wr(CAUSE_OFFSET, 32'h0);
		rd_chk(CAUSE_OFFSET, 32'h0);
		// Only the low byte lane is enabled, so the upper half must stay clear.
		strb <= 4'h1;
		wr(CAUSE_OFFSET, 32'hFFFF);
		strb <= 4'hF;
		rd_chk(CAUSE_OFFSET, 32'h00FF);
		wr(CAUSE_OFFSET, 32'h0);
		sleep_in <= 1'b1;
		idle_in <= 1'b1;
		@(posedge aclk);
		sleep_in <= 1'b0;
		idle_in <= 1'b0;
		rd_chk(CAUSE_OFFSET, 32'h000C);
		wr(CAUSE_OFFSET, 32'h0);
	endtask : t_soft

	task t_wdt;
		repeat (3) @(posedge aclk);
		check(32'(wrun), 32'h1);
		fuse <= 2'h0;
		repeat (3) @(posedge aclk);
		check(32'(wrun), 32'h0);
		wr(CAUSE_OFFSET, 32'h20);
		repeat (3) @(posedge aclk);
		check(32'(wrun), 32'h1);
		fuse <= 2'h3;
	endtask : t_wdt

	task t_irq;
		wr(IRQ_STATUS_OFFSET, 32'hFFFF);
		wr(IRQ_MASK_OFFSET, 32'h0);
		pulse(SRC_PIN);
		rd_chk(IRQ_STATUS_OFFSET, 32'h80);
		check(32'(irq), 32'h0);
		wr(IRQ_MASK_OFFSET, 32'h80);
		repeat (2) @(posedge aclk);
		check(32'(irq), 32'h1);
		wr(IRQ_STATUS_OFFSET, 32'h80);
		repeat (2) @(posedge aclk);
		check(32'(irq), 32'h0);
		rd_chk(IRQ_STATUS_OFFSET, 32'h0);
	endtask : t_irq

	task t_bus;
		axi_rd(32'h10, d, r);
		check(d, 32'h0);
		check(32'(r), 32'(RESP_SLVERR));
		axi_wr(WDT_STATE_OFFSET, 32'h1, r);
		check(32'(r), 32'(RESP_SLVERR));
		axi_rd(WDT_STATE_OFFSET, d, r);
		check(32'(r), 32'(RESP_OKAY));
		check(d, 32'h1);
	endtask : t_bus

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(CAUSE_OFFSET, 32'h2003);
		t_sources();
		t_soft();
		wr(CAUSE_OFFSET, 32'h0080);
		pulse(SRC_POR);
		rd_chk(CAUSE_OFFSET, 32'h2003);
		t_wdt();
		t_irq();
		t_bus();
		end_sim();
	end
endmodule : reset_combiner_tb
